// File: hdl/stream_err_pkg.sv
// Package of constants for the streaming read error report block
// Function
// - Continuous-read bit keeps transfer going on errors
// - Sector number, select low, gives bits 7:0
// - Sector number, select high, gives bits 31:24
// - Cylinder low gives bits 15:8 or 39:32
// - Cylinder high gives bits 23:16 or 47:40
// - Time-limit-out error bit 0 set on expiry
// - Stream-error status bit 5 on continuous-read errors
// - Reported address is first sector in error
// - Sector count holds suspect consecutive sector count
// - Continuous mode: stream error, error bit cleared, log
package stream_err_pkg;
    // Task-file register indices
    localparam logic [2:0] ADDR_ERROR = 3'h1;
    localparam logic [2:0] ADDR_FEATURE = 3'h1;
    localparam logic [2:0] ADDR_COUNT = 3'h2;
    localparam logic [2:0] ADDR_SECNUM = 3'h3;
    localparam logic [2:0] ADDR_CYL_LO = 3'h4;
    localparam logic [2:0] ADDR_CYL_HI = 3'h5;
    localparam logic [2:0] ADDR_CONTROL = 3'h6;
    localparam logic [2:0] ADDR_STATUS = 3'h7;
    // Field positions
    localparam int RC_BIT = 6;
    localparam int HOB_BIT = 7;
    localparam int SE_BIT = 5;
    localparam int ERR_BIT = 0;
    localparam int RDY_BIT = 6;
    localparam int BSY_BIT = 7;
    localparam int CCTO_BIT = 0;
    localparam int ABRT_BIT = 2;
    localparam int IDNF_BIT = 4;
    localparam int UNC_BIT = 6;
    localparam int CRC_BIT = 7;
    // Reset values
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [47:0] LBA_RST = 48'h000000000000;
    localparam logic [15:0] COUNT_RST = 16'h0000;
endpackage

// File: hdl/tf_byte_pair.sv
// Current/previous byte pair of one task-file register
`timescale 1ns/1ns
module tf_byte_pair (
    input wire logic clk,
    input wire logic srst,
    input wire logic wr,
    input wire logic [7:0] din,
    output logic [7:0] cur_reg,
    output logic [7:0] prev_reg
);
    // Each write pushes the old current byte into the previous slot
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_reg <= stream_err_pkg::BYTE_RST;
            prev_reg <= stream_err_pkg::BYTE_RST;
        end else if (wr) begin
            prev_reg <= cur_reg;
            cur_reg <= din;
        end
    end
endmodule

// File: hdl/stream_read_error_report.sv
// Streaming read error report: task file capture and ending results
//
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ns
module stream_read_error_report (
    input wire logic clk,
    input wire logic srst,
    input wire logic [2:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr_stb,
    input wire logic rd_stb,
    output logic [7:0] rdata,
    input wire logic cmd_start,
    input wire logic sector_err,
    input wire logic sector_done,
    input wire logic [4:0] err_kind,
    input wire logic time_expired,
    input wire logic cmd_done,
    output logic [47:0] start_lba,
    output logic cont_read,
    output logic stop_xfer,
    output logic busy,
    output logic [7:0] err_log
);
    ///////////////////////////////////////////////////////////////////////
    // Task-file bytes
    logic [7:0] sn_cur, sn_prev; // Sector number pair
    logic [7:0] cl_cur, cl_prev; // Cylinder low pair
    logic [7:0] ch_cur, ch_prev; // Cylinder high pair
    // Only the current feature byte matters here; its previous byte carries the
    // time limit, which is counted outside this block, so it is left unconnected
    logic [7:0] ft_cur;
    logic hob_reg; // High-order byte select
    tf_byte_pair u_sn (.clk(clk), .srst(srst), .wr(wr_stb && addr == stream_err_pkg::ADDR_SECNUM),
        .din(wdata), .cur_reg(sn_cur), .prev_reg(sn_prev));
    tf_byte_pair u_cl (.clk(clk), .srst(srst), .wr(wr_stb && addr == stream_err_pkg::ADDR_CYL_LO),
        .din(wdata), .cur_reg(cl_cur), .prev_reg(cl_prev));
    tf_byte_pair u_ch (.clk(clk), .srst(srst), .wr(wr_stb && addr == stream_err_pkg::ADDR_CYL_HI),
        .din(wdata), .cur_reg(ch_cur), .prev_reg(ch_prev));
    tf_byte_pair u_ft (.clk(clk), .srst(srst), .wr(wr_stb && addr == stream_err_pkg::ADDR_FEATURE),
        .din(wdata), .cur_reg(ft_cur), .prev_reg());

    // Control byte holds the high-order select
    // Only bit 7 is kept; the rest of the control byte belongs to other logic
    always_ff @(posedge clk) begin
        if (srst) begin
            hob_reg <= 1'b0;
        end else if (wr_stb && addr == stream_err_pkg::ADDR_CONTROL) begin
            hob_reg <= wdata[stream_err_pkg::HOB_BIT];
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Command capture at issue
    always_ff @(posedge clk) begin
        if (srst) begin
            start_lba <= stream_err_pkg::LBA_RST;
            cont_read <= 1'b0;
        end else if (cmd_start) begin
            start_lba <= {ch_prev, cl_prev, sn_prev, ch_cur, cl_cur, sn_cur};
            cont_read <= ft_cur[stream_err_pkg::RC_BIT];
        end
    end

    // Busy flag for the life of the command
    // A new issue wins over a same-cycle end, so a back-to-back command is not lost
    always_ff @(posedge clk) begin
        if (srst) begin
            busy <= 1'b0;
        end else if (cmd_start) begin
            busy <= 1'b1;
        end else if (cmd_done || stop_xfer) begin
            busy <= 1'b0;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Error tracking
    logic [47:0] cur_lba_reg; // Address of the sector now in flight
    logic [47:0] err_lba_reg; // First failing address
    logic [15:0] err_cnt_reg; // Suspect run length
    logic run_open_reg; // Run still contiguous
    logic seen_err_reg; // First error already recorded this command
    logic se_reg; // Stream-error status bit
    logic err_reg; // Error status bit
    logic [7:0] err_bits_reg; // Error register image

    // Sector address walks forward each finished sector
    // Wraps silently at the top of the address space; a host never asks for that
    always_ff @(posedge clk) begin
        if (srst) begin
            cur_lba_reg <= stream_err_pkg::LBA_RST;
        end else if (cmd_start) begin
            cur_lba_reg <= {ch_prev, cl_prev, sn_prev, ch_cur, cl_cur, sn_cur};
        end else if (busy && sector_done) begin
            cur_lba_reg <= cur_lba_reg + 48'h1;
        end
    end

    // First error address and consecutive suspect count
    // Only the first run is counted; errors after a clean sector leave it alone
    always_ff @(posedge clk) begin
        if (srst) begin
            err_lba_reg <= stream_err_pkg::LBA_RST;
            err_cnt_reg <= stream_err_pkg::COUNT_RST;
            run_open_reg <= 1'b0;
            seen_err_reg <= 1'b0;
        end else if (cmd_start) begin
            err_cnt_reg <= stream_err_pkg::COUNT_RST;
            run_open_reg <= 1'b0;
            seen_err_reg <= 1'b0;
        end else if (busy && sector_done) begin
            if (sector_err && !seen_err_reg) begin
                err_lba_reg <= cur_lba_reg;
                err_cnt_reg <= 16'h0001;
                run_open_reg <= 1'b1;
                seen_err_reg <= 1'b1;
            end else if (sector_err && run_open_reg) begin
                err_cnt_reg <= err_cnt_reg + 16'h0001;
            end else begin
                run_open_reg <= 1'b0; // A clean sector ends the run
            end
        end
    end

    // Ending status and error log
    always_ff @(posedge clk) begin
        if (srst) begin
            se_reg <= 1'b0;
            err_reg <= 1'b0;
            err_bits_reg <= stream_err_pkg::BYTE_RST;
            err_log <= stream_err_pkg::BYTE_RST;
            stop_xfer <= 1'b0;
        end else if (cmd_start) begin
            se_reg <= 1'b0;
            err_reg <= 1'b0;
            err_bits_reg <= stream_err_pkg::BYTE_RST;
            stop_xfer <= 1'b0;
        end else if (busy) begin
            stop_xfer <= 1'b0;
            if (time_expired) begin
                // Expiry always ends the command, even in continuous mode
                stop_xfer <= 1'b1;
                if (cont_read) begin
                    se_reg <= 1'b1;
                    err_log[stream_err_pkg::CCTO_BIT] <= 1'b1;
                end else begin
                    err_reg <= 1'b1;
                    err_bits_reg[stream_err_pkg::CCTO_BIT] <= 1'b1;
                end
            end else if (sector_done && sector_err) begin
                if (cont_read) begin
                    se_reg <= 1'b1;
                    err_log <= err_log | {err_kind[4], err_kind[3], 1'b0, err_kind[2], 1'b0,
                        err_kind[1], 1'b0, err_kind[0]};
                end else begin
                    // Normal mode aborts on the first error
                    err_reg <= 1'b1;
                    stop_xfer <= 1'b1;
                    err_bits_reg <= {err_kind[4], err_kind[3], 1'b0, err_kind[2], 1'b0,
                        err_kind[1], 1'b0, err_kind[0]};
                end
            end
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Register read port, data valid the cycle after the strobe
    // Idle cycles read zero so a stale byte is never mistaken for fresh data
    always_ff @(posedge clk) begin
        if (srst) begin
            rdata <= stream_err_pkg::BYTE_RST;
        end else if (rd_stb) begin
            case (addr)
                stream_err_pkg::ADDR_ERROR: rdata <= err_bits_reg;
                stream_err_pkg::ADDR_COUNT: rdata <= hob_reg ? err_cnt_reg[15:8] : err_cnt_reg[7:0];
                stream_err_pkg::ADDR_SECNUM: rdata <= hob_reg ? err_lba_reg[31:24] : err_lba_reg[7:0];
                stream_err_pkg::ADDR_CYL_LO: rdata <= hob_reg ? err_lba_reg[39:32] : err_lba_reg[15:8];
                stream_err_pkg::ADDR_CYL_HI: rdata <= hob_reg ? err_lba_reg[47:40] : err_lba_reg[23:16];
                stream_err_pkg::ADDR_STATUS: rdata <= {busy, !busy, se_reg, 4'h0, err_reg};
                default: rdata <= stream_err_pkg::BYTE_RST;
            endcase
        end else begin
            rdata <= stream_err_pkg::BYTE_RST;
        end
    end

    ///////////////////////////////////////////////////////////////////////
    // Checks
    // Read data are compared with the state seen at the strobe edge, hence $past
    a_lba_capture: assert property (@(posedge clk) disable iff (srst)
        cmd_start |=> start_lba == {$past(ch_prev), $past(cl_prev), $past(sn_prev),
            $past(ch_cur), $past(cl_cur), $past(sn_cur)}) else $error("start address wrong");
    a_rc_no_stop: assert property (@(posedge clk) disable iff (srst)
        busy && cont_read && !time_expired && !cmd_start |=> !stop_xfer) else $error("continuous stopped");
    a_secnum_low: assert property (@(posedge clk) disable iff (srst)
        rd_stb && addr == 3'h3 && !hob_reg |=> rdata == $past(err_lba_reg[7:0])) else $error("secnum low");
    a_secnum_high: assert property (@(posedge clk) disable iff (srst)
        rd_stb && addr == 3'h3 && hob_reg |=> rdata == $past(err_lba_reg[31:24])) else $error("secnum high");
    a_cyl_lo_read: assert property (@(posedge clk) disable iff (srst)
        rd_stb && addr == 3'h4 |=> rdata == ($past(hob_reg) ? $past(err_lba_reg[39:32])
            : $past(err_lba_reg[15:8]))) else $error("cyl low");
    a_cyl_hi_read: assert property (@(posedge clk) disable iff (srst)
        rd_stb && addr == 3'h5 |=> rdata == ($past(hob_reg) ? $past(err_lba_reg[47:40])
            : $past(err_lba_reg[23:16]))) else $error("cyl high");
    a_ccto_set: assert property (@(posedge clk) disable iff (srst)
        busy && time_expired && !cont_read && !cmd_start |=> err_bits_reg[0] && stop_xfer) else $error("ccto");
    a_se_set: assert property (@(posedge clk) disable iff (srst)
        busy && cont_read && sector_done && sector_err && !cmd_start |=> se_reg && !err_reg) else $error("se");
    a_first_addr: assert property (@(posedge clk) disable iff (srst)
        busy && sector_done && sector_err && !seen_err_reg && !cmd_start
            |=> err_lba_reg == $past(cur_lba_reg) && err_cnt_reg == 16'h0001) else $error("first addr");
    a_run_grow: assert property (@(posedge clk) disable iff (srst)
        busy && sector_done && sector_err && run_open_reg && !cmd_start
            |=> err_cnt_reg == $past(err_cnt_reg) + 16'h0001) else $error("count");
    a_rc_log: assert property (@(posedge clk) disable iff (srst)
        busy && cont_read && time_expired && !cmd_start |=> err_log[0] && se_reg && !err_reg) else $error("log");
    // Continuous mode never raises the error bit nor fills the error register
    a_rc_err_clear: assert property (@(posedge clk) disable iff (srst)
        cont_read |-> !err_reg && err_bits_reg == stream_err_pkg::BYTE_RST) else $error("error bit in continuous");
    // Main scenarios the bench is meant to reach
    c_rc_error: cover property (@(posedge clk) busy && cont_read && sector_err && sector_done);
    c_timeout: cover property (@(posedge clk) busy && time_expired);
    c_hob_read: cover property (@(posedge clk) rd_stb && hob_reg && addr == 3'h3);
    c_run_grow: cover property (@(posedge clk) busy && sector_done && sector_err && run_open_reg);
    c_normal_abort: cover property (@(posedge clk) busy && !cont_read && sector_done && sector_err);
endmodule

// File: bench/host_model.sv
// Host controller model driving the task-file port
`timescale 1ns/1ns
module host_model (
    input wire logic clk,
    input wire logic [7:0] rdata,
    output logic [2:0] addr,
    output logic [7:0] wdata,
    output logic wr_stb,
    output logic rd_stb
);
    // Quiet bus at time zero
    initial begin
        addr = 3'h0;
        wdata = 8'h00;
        wr_stb = 1'b0;
        rd_stb = 1'b0;
    end
    // One-cycle write; released lines show inverted values, never a stale copy
    task automatic wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr_stb <= 1'b1;
        @(posedge clk);
        wr_stb <= 1'b0;
        addr <= ~a;
        wdata <= ~d;
    endtask
    // One-cycle read; data stand only in the cycle after the strobe
    task automatic rd(input logic [2:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd_stb <= 1'b1;
        @(posedge clk);
        rd_stb <= 1'b0;
        addr <= ~a;
        #1 d = rdata;
    endtask
    // Results fetched twice, select low then select high
    task automatic rd_pair(input logic [2:0] a, output logic [15:0] d);
        logic [7:0] lo, hi;
        wr(stream_err_pkg::ADDR_CONTROL, 8'h00);
        rd(a, lo);
        wr(stream_err_pkg::ADDR_CONTROL, 8'h80);
        rd(a, hi);
        d = {hi, lo};
    endtask
endmodule

// File: bench/tb_top.sv
// Self-checking bench for the streaming read error report block
`timescale 1ns/1ns
module tb_top;
    logic clk, srst, cmd_start, sector_err, sector_done, time_expired, cmd_done;
    logic [4:0] err_kind;
    logic [2:0] addr;
    logic [7:0] wdata, rdata, err_log;
    logic wr_stb, rd_stb, cont_read, stop_xfer, busy;
    logic [47:0] start_lba;
    int n_fail, cmp_count, n_stop;
    int seed = 40101;
    //////////////////////////////////////////////////////////////////
    stream_read_error_report stream_read_error_report_i (.clk(clk), .srst(srst), .addr(addr), .wdata(wdata),
        .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .cmd_start(cmd_start), .sector_err(sector_err),
        .sector_done(sector_done), .err_kind(err_kind), .time_expired(time_expired), .cmd_done(cmd_done),
        .start_lba(start_lba), .cont_read(cont_read), .stop_xfer(stop_xfer), .busy(busy), .err_log(err_log));
    host_model host_model_i (.clk(clk), .rdata(rdata), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb));
    // 100 ns clock
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    // Abort pulses are one cycle, so count them at every edge
    always @(posedge clk) begin
        if (stop_xfer === 1'b1) n_stop++;
    end
    //////////////////////////////////////////////////////////////////
    // Error register image of an error kind vector
    function automatic logic [7:0] emap(input logic [4:0] k);
        return {k[4], k[3], 1'b0, k[2], 1'b0, k[1], 1'b0, k[0]};
    endfunction
    // Verdict and end of run
    task automatic wrap_up();
        if (n_fail == 0 && cmp_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic check(input logic [47:0] got, input logic [47:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // One-cycle pulse on a sequencer input; idle levels inverted afterwards
    task automatic sec(input logic e, input logic [4:0] k);
        @(posedge clk);
        sector_done <= 1'b1;
        sector_err <= e;
        err_kind <= k;
        @(posedge clk);
        sector_done <= 1'b0;
        sector_err <= ~e;
        err_kind <= ~k;
    endtask
    // One command: rc selects continuous mode, tmo ends it by time limit
    task automatic run(input logic rc, input logic tmo);
        logic [47:0] lba;
        logic [15:0] sn, cl, ch, cnt;
        logic [7:0] st, er;
        logic [4:0] kind;
        int k, stops;
        lba = {16'($random(seed)), 32'($random(seed))};
        kind = 5'h01 << (1 + $unsigned($random(seed)) % 4);
        k = $unsigned($random(seed)) % 3;
        for (int r = 0; r < 3; r++) begin
            host_model_i.wr(3'(stream_err_pkg::ADDR_SECNUM + r), lba[24 + 8 * r +: 8]);
            host_model_i.wr(3'(stream_err_pkg::ADDR_SECNUM + r), lba[8 * r +: 8]);
        end
        host_model_i.wr(stream_err_pkg::ADDR_FEATURE, {1'b1, rc, 6'($random(seed))});
        @(posedge clk);
        cmd_start <= 1'b1;
        @(posedge clk);
        cmd_start <= 1'b0;
        #1 check(start_lba, lba);
        check({47'h0, cont_read}, {47'h0, rc});
        stops = n_stop;
        if (tmo) begin
            sec(1'b0, 5'h00);
            @(posedge clk);
            time_expired <= 1'b1;
            @(posedge clk);
            time_expired <= 1'b0;
        end else begin
            // Continuous: error run of two at k, then a lone error at k+3; normal: sectors stop at the first error at k
            for (int i = 0; i < (rc ? 6 : k + 1); i++) sec(i == k || i == k + 1 || i == k + 3, kind);
        end
        @(posedge clk);
        cmd_done <= 1'b1;
        @(posedge clk);
        cmd_done <= 1'b0;
        for (int i = 0; i < 20 && busy !== 1'b0; i++) @(posedge clk);
        if (busy !== 1'b0) begin
            n_fail++;
            wrap_up();
        end
        check(n_stop - stops, (rc && !tmo) ? 0 : 1);
        if (!tmo) begin
            host_model_i.rd_pair(stream_err_pkg::ADDR_SECNUM, sn);
            host_model_i.rd_pair(stream_err_pkg::ADDR_CYL_LO, cl);
            host_model_i.rd_pair(stream_err_pkg::ADDR_CYL_HI, ch);
            check({ch[15:8], cl[15:8], sn[15:8], ch[7:0], cl[7:0], sn[7:0]}, lba + k);
        end
        if (rc && !tmo) begin
            host_model_i.rd_pair(stream_err_pkg::ADDR_COUNT, cnt);
            check(cnt, 16'h0002);
        end
        host_model_i.rd(stream_err_pkg::ADDR_STATUS, st);
        host_model_i.rd(stream_err_pkg::ADDR_ERROR, er);
        check(st & 8'he1, rc ? 8'h60 : 8'h41);
        check(er, rc ? 8'h00 : (tmo ? 8'h01 : emap(kind)));
        if (rc) check(err_log & emap(tmo ? 5'h01 : kind), emap(tmo ? 5'h01 : kind));
    endtask
    //////////////////////////////////////////////////////////////////
    // Reset for ten cycles, then continuous, normal and time-limit commands
    initial begin
        srst = 1'b1;
        cmd_start = 1'b0;
        sector_err = 1'b0;
        sector_done = 1'b0;
        err_kind = 5'h00;
        time_expired = 1'b0;
        cmd_done = 1'b0;
        repeat (10) @(posedge clk);
        srst <= 1'b0;
        @(posedge clk);
        #1 check(start_lba, 48'h0);
        run(1'b1, 1'b0);
        run(1'b0, 1'b0);
        run(1'b0, 1'b1);
        run(1'b1, 1'b1);
        run(1'b1, 1'b0);
        wrap_up();
    end
endmodule
